// File: rtl/spb_packet_path.sv
// slow port packet path: transmit and receive packet memories behind an avalon slave
// Notes on behaviour
// RL1: transmit packet lives in a 64 x 512-bit dual-port memory.
// RL2: 32-bit cpu writes become byte enables on the 512-bit word.
// RL3: cpu checks busy reads zero before preparing a new packet.
// RL4: cpu starts packets at address zero, at most 4 Kbytes.
// RL5: cpu programs byte length, then raises the transmit request.
// RL6: request passes synchronising registers and sets the busy flag.
// RL7: beat count from upper length bits rounded up; low bits give final keep.
// RL8: first word read then valid; each accepted beat advances address, counts down.
// RL9: count of one gives last with final keep; other beats keep all ones.
// RL10: mac may drop ready; the current beat is held meanwhile.
// RL11: after the last beat an end flag syncs back and clears busy.
// RL12: accepted packets are stored in a 64 x 512-bit memory.
// RL13: user keeps header value and mask fixed while receive enabled.
// RL14: first beat bytes 0..37 compared, one mask bit enables each byte.
// RL15: packet is stored only when all 38 match flags are one.
// RL16: accept only with receive enable set and fifo count bit 4 clear.
// RL17: every valid beat of an accepted packet is stored, address advances.
// RL18: end of packet gives a one-cycle pulse writing end address to fifo.
// RL19: end address fifo holds 16 entries, so 16 queued packets.
// RL20: end address fifo is first word fall through.
// RL21: cpu waits not empty, reads end address, then acknowledges to pop.
// RL22: cpu converts 512-bit end address to 32-bit address and reads up to it.
// RL23: cpu read selects one of sixteen 32-bit slices of the memory word.
// RL24: cpu reads of the receive memory path return after four cycles.
// RL25: rejected packet leaves memory, write address and fifo untouched.
`timescale 1ns/1ns
module spb_packet_path
  import spb_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // avalon-mm register slave
  input wire logic [spb_pkg::AVS_AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // transmit stream to mac
  output logic [spb_pkg::DATA_W-1:0] TX_TDATA,
  output logic [spb_pkg::KEEP_W-1:0] TX_TKEEP,
  output logic TX_TVALID,
  output logic TX_TLAST,
  input wire logic TX_TREADY,
  // receive stream from mac
  input wire logic [spb_pkg::DATA_W-1:0] RX_TDATA,
  input wire logic RX_TVALID,
  input wire logic RX_TLAST
);
  import spb_pkg::*;

  function automatic logic [1:0] region_of(input logic [AVS_AW-1:0] a);
    region_of = a[13:12];
  endfunction

  function automatic logic word_is(input logic [AVS_AW-1:0] a, input logic [AVS_AW-1:0] off);
    word_is = (a[13:12] == REGION_REG) && (a[11:2] == off[11:2]);
  endfunction

  function automatic logic [KEEP_W-1:0] keep_of(input logic [5:0] n);
    keep_of = (n == 6'h00) ? {KEEP_W{1'b1}} : ~({KEEP_W{1'b1}} << n);
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge_be = old;
  endfunction

  spb_ram_if #(.DW(DATA_W), .AW(RAM_AW)) tx_mem ();
  spb_ram_if #(.DW(DATA_W), .AW(RAM_AW)) rx_mem ();

  spb_ram #(.DW(DATA_W), .AW(RAM_AW)) transmit_packet_memory (
    .clk(CLK), .rst(SYS_RST), .ce(CE), .bus(tx_mem.mem)); // [RL1]
  spb_ram #(.DW(DATA_W), .AW(RAM_AW)) receive_packet_memory (
    .clk(CLK), .rst(SYS_RST), .ce(CE), .bus(rx_mem.mem)); // [RL12]

  // register bus decode
  logic wr_ctrl, wr_len, wr_stat;
  logic [2:0] rd_cnt_q;
  logic [31:0] rd_mux;
  logic [31:0] rx_slice_q;
  logic [3:0] slice;
  assign slice = AVS_ADDRESS[5:2];
  assign wr_ctrl = AVS_WRITE && word_is(AVS_ADDRESS, REG_CTRL);
  assign wr_len = AVS_WRITE && word_is(AVS_ADDRESS, REG_TX_LEN);
  assign wr_stat = AVS_WRITE && word_is(AVS_ADDRESS, REG_RX_STAT);
  // writes finish at once; every read waits the receive memory path so all reads look alike
  assign AVS_WAITREQUEST = AVS_READ && (rd_cnt_q != RD_LAT_CYC); // [RL24]

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rd_cnt_q <= '0;
    end else if (CE && AVS_READ) begin
      rd_cnt_q <= (rd_cnt_q == RD_LAT_CYC) ? 3'h0 : rd_cnt_q + 3'h1;
    end
  end

  // control registers
  logic [LEN_W-1:0] tx_len_q;
  logic rx_en_q;
  logic [HDR_WORDS*32-1:0] hdr_q;
  logic [63:0] mask_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tx_len_q <= '0;
      rx_en_q <= 1'b0;
      hdr_q <= '0;
      mask_q <= '0;
    end else if (CE && AVS_WRITE) begin
      if (wr_len) begin
        tx_len_q <= LEN_W'(merge_be(32'(tx_len_q), AVS_WRITEDATA, AVS_BYTEENABLE));
      end
      if (wr_ctrl && AVS_BYTEENABLE[0]) begin
        rx_en_q <= AVS_WRITEDATA[CTRL_EN_BIT];
      end
      for (int i = 0; i < HDR_WORDS; i++) begin
        if (word_is(AVS_ADDRESS, REG_HDR_BASE + 14'(i*4))) begin
          hdr_q[i*32 +: 32] <= merge_be(hdr_q[i*32 +: 32], AVS_WRITEDATA, AVS_BYTEENABLE);
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (word_is(AVS_ADDRESS, REG_MASK_BASE + 14'(i*4))) begin
          mask_q[i*32 +: 32] <= merge_be(mask_q[i*32 +: 32], AVS_WRITEDATA, AVS_BYTEENABLE);
        end
      end
    end
  end

  // transmit request and end events through synchronising registers
  logic busy_q, req_tgl_q, end_tgl_q, start_seen_q, end_seen_q, start_evt, end_evt, req_take;
  logic [1:0] start_sync_q, end_sync_q;
  assign req_take = wr_ctrl && AVS_BYTEENABLE[0] && AVS_WRITEDATA[CTRL_REQ_BIT] && !busy_q;
  assign start_evt = start_sync_q[1] ^ start_seen_q;
  assign end_evt = end_sync_q[1] ^ end_seen_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      busy_q <= 1'b0;
      req_tgl_q <= 1'b0;
      start_sync_q <= '0;
      start_seen_q <= 1'b0;
      end_sync_q <= '0;
      end_seen_q <= 1'b0;
    end else if (CE) begin
      start_sync_q <= {start_sync_q[0], req_tgl_q}; // [RL6]
      start_seen_q <= start_sync_q[1];
      end_sync_q <= {end_sync_q[0], end_tgl_q}; // [RL11]
      end_seen_q <= end_sync_q[1];
      if (req_take) begin
        req_tgl_q <= ~req_tgl_q;
        busy_q <= 1'b1; // [RL6]
      end else if (end_evt) begin
        busy_q <= 1'b0; // [RL11]
      end
    end
  end

  // transmit sequencer
  spb_tx_state_e tx_state_q;
  logic [RAM_AW-1:0] tx_addr_q;
  logic [BEAT_W-1:0] beats_q;
  logic [KEEP_W-1:0] final_keep_q;
  logic tx_fire;
  assign TX_TVALID = (tx_state_q == TX_SEND);
  assign tx_fire = TX_TVALID && TX_TREADY;
  assign TX_TLAST = TX_TVALID && (beats_q == BEAT_W'(1)); // [RL9]
  assign TX_TKEEP = TX_TLAST ? final_keep_q : {KEEP_W{1'b1}}; // [RL9]
  assign TX_TDATA = tx_mem.rd_data;
  // the read port looks one word ahead on a taken beat so a stall keeps the same word
  assign tx_mem.rd_addr = tx_fire ? tx_addr_q + RAM_AW'(1) : tx_addr_q; // [RL10]
  assign tx_mem.wr_en = CE && AVS_WRITE && (region_of(AVS_ADDRESS) == REGION_TXMEM);
  assign tx_mem.wr_addr = AVS_ADDRESS[11:6];
  assign tx_mem.wr_be = KEEP_W'(AVS_BYTEENABLE) << {slice, 2'b00}; // [RL2]
  assign tx_mem.wr_data = {(DATA_W/32){AVS_WRITEDATA}};

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tx_state_q <= TX_IDLE;
      tx_addr_q <= '0;
      beats_q <= '0;
      final_keep_q <= '1;
      end_tgl_q <= 1'b0;
    end else if (CE) begin
      case (tx_state_q)
        TX_IDLE: begin
          if (start_evt) begin
            beats_q <= tx_len_q[12:6] + BEAT_W'(|tx_len_q[5:0]); // [RL7]
            final_keep_q <= keep_of(tx_len_q[5:0]); // [RL7]
            tx_addr_q <= '0;
            tx_state_q <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          if (beats_q == '0) begin
            end_tgl_q <= ~end_tgl_q;
            tx_state_q <= TX_IDLE;
          end else begin
            tx_state_q <= TX_SEND; // [RL8]
          end
        end
        TX_SEND: begin
          if (tx_fire) begin
            tx_addr_q <= tx_addr_q + RAM_AW'(1); // [RL8]
            beats_q <= beats_q - BEAT_W'(1); // [RL8]
            if (beats_q == BEAT_W'(1)) begin
              end_tgl_q <= ~end_tgl_q; // [RL11]
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // receive header check and acceptance
  logic [HDR_BYTES-1:0] header_match_flags;
  logic in_pkt_q, accept_q, first_beat, accept_now, rx_we, push_q, pop;
  logic [RAM_AW-1:0] rx_addr_q, end_word_q;
  logic [FIFO_CW-1:0] fifo_cnt_q, fifo_occ;
  logic [FIFO_AW-1:0] fifo_wp_q, fifo_rp_q;
  logic [RAM_AW-1:0] fifo_q [FIFO_DEPTH];

  for (genvar i = 0; i < HDR_BYTES; i++) begin : g_hdr
    assign header_match_flags[i] = !mask_q[i] || (RX_TDATA[i*8 +: 8] == hdr_q[i*8 +: 8]); // [RL14]
  end

  // a push still in flight counts as taken space
  assign fifo_occ = fifo_cnt_q + FIFO_CW'(push_q);
  assign first_beat = RX_TVALID && !in_pkt_q; // [RL14]
  assign accept_now = (&header_match_flags) && rx_en_q && !fifo_occ[FIFO_FULL_BIT]; // [RL15] [RL16]
  assign rx_we = RX_TVALID && (first_beat ? accept_now : accept_q); // [RL17] [RL25]
  assign rx_mem.wr_en = CE && rx_we;
  assign rx_mem.wr_addr = rx_addr_q;
  assign rx_mem.wr_be = {KEEP_W{1'b1}};
  assign rx_mem.wr_data = RX_TDATA;
  assign rx_mem.rd_addr = AVS_ADDRESS[11:6];

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      in_pkt_q <= 1'b0;
      accept_q <= 1'b0;
      rx_addr_q <= '0;
      push_q <= 1'b0;
      end_word_q <= '0;
    end else if (CE) begin
      push_q <= rx_we && RX_TLAST; // [RL18]
      if (RX_TVALID) begin
        in_pkt_q <= !RX_TLAST;
      end
      if (first_beat) begin
        accept_q <= accept_now;
      end
      if (rx_we) begin
        rx_addr_q <= rx_addr_q + RAM_AW'(1); // [RL17]
        end_word_q <= rx_addr_q; // [RL18]
      end
    end
  end

  // end address fifo, first word fall through
  assign pop = wr_stat && AVS_BYTEENABLE[0] && AVS_WRITEDATA[STAT_ACK_BIT] && (fifo_cnt_q != '0);
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      fifo_wp_q <= '0;
      fifo_rp_q <= '0;
      fifo_cnt_q <= '0;
    end else if (CE) begin
      if (push_q) begin
        fifo_q[fifo_wp_q] <= end_word_q; // [RL19]
        fifo_wp_q <= fifo_wp_q + FIFO_AW'(1);
      end
      if (pop) begin
        fifo_rp_q <= fifo_rp_q + FIFO_AW'(1);
      end
      fifo_cnt_q <= fifo_cnt_q + FIFO_CW'(push_q) - FIFO_CW'(pop);
    end
  end

  // read data: memory word, slice select, then output register
  always_comb begin
    rd_mux = '0;
    if (word_is(AVS_ADDRESS, REG_CTRL)) begin
      rd_mux[CTRL_REQ_BIT] = busy_q;
      rd_mux[CTRL_EN_BIT] = rx_en_q;
    end else if (word_is(AVS_ADDRESS, REG_TX_LEN)) begin
      rd_mux = 32'(tx_len_q);
    end else if (word_is(AVS_ADDRESS, REG_RX_STAT)) begin
      rd_mux[STAT_EMPTY_BIT] = (fifo_cnt_q == '0);
      rd_mux[STAT_CNT_LSB +: FIFO_CW] = fifo_cnt_q;
    end else if (word_is(AVS_ADDRESS, REG_END_WORD)) begin
      rd_mux = 32'(fifo_q[fifo_rp_q]); // [RL20]
    end else if ((region_of(AVS_ADDRESS) == REGION_REG) && (AVS_ADDRESS[11:6] == REG_HDR_BASE[11:6])
                 && (AVS_ADDRESS[5:2] < 4'(HDR_WORDS))) begin
      rd_mux = hdr_q[slice*32 +: 32];
    end else if ((region_of(AVS_ADDRESS) == REGION_REG) && (AVS_ADDRESS[11:3] == REG_MASK_BASE[11:3])) begin
      rd_mux = mask_q[AVS_ADDRESS[2]*32 +: 32];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_slice_q <= '0;
      AVS_READDATA <= '0;
    end else if (CE) begin
      rx_slice_q <= rx_mem.rd_data[slice*32 +: 32]; // [RL23]
      AVS_READDATA <= (region_of(AVS_ADDRESS) == REGION_RXMEM) ? rx_slice_q : rd_mux;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST || !CE);
  sequence rd_wait_s;
    AVS_WAITREQUEST [*4];
  endsequence
  sequence end_back_s;
    ##[1:8] !busy_q;
  endsequence
  // an end beat followed by a quiet cycle, so the push pulse can be seen falling
  sequence last_alone_s;
    rx_we && RX_TLAST ##1 !(rx_we && RX_TLAST);
  endsequence
  busy_set_a: assert property (req_take |=> busy_q) // [RL6]
    else $error("busy not raised after request");
  tx_last_a: assert property (tx_fire && TX_TLAST |=> !TX_TVALID && beats_q == '0) // [RL9]
    else $error("beat offered after the final one");
  keep_full_a: assert property (TX_TVALID && !TX_TLAST |-> TX_TKEEP == {KEEP_W{1'b1}}) // [RL9]
    else $error("non final beat with partial keep");
  stall_hold_a: assert property (TX_TVALID && !TX_TREADY |=> TX_TVALID && $stable(tx_addr_q) && $stable(beats_q)) // [RL10]
    else $error("beat changed while stalled");
  beat_adv_a: assert property (tx_fire && !TX_TLAST |=> tx_addr_q == $past(tx_addr_q) + RAM_AW'(1)) // [RL8]
    else $error("read address did not advance");
  end_clear_a: assert property (tx_fire && TX_TLAST |-> end_back_s) // [RL11]
    else $error("busy not cleared after final beat");
  reject_keep_a: assert property (first_beat && !accept_now |-> !rx_we ##1 ($stable(rx_addr_q) && !push_q)) // [RL25]
    else $error("rejected packet written");
  fifo_push_a: assert property (last_alone_s |-> push_q ##1 !push_q) // [RL18]
    else $error("end address push not a single pulse");
  rd_latency_a: assert property (AVS_READ && rd_cnt_q == 3'h0 |-> rd_wait_s ##1 !AVS_WAITREQUEST) // [RL24]
    else $error("read answer not after four cycles");
  full_block_a: assert property (first_beat && fifo_occ[FIFO_FULL_BIT] |-> !rx_we) // [RL16]
    else $error("packet stored with fifo full");
endmodule

// File: rtl/spb_pkg.sv
// constants, offsets and types shared by the slow port packet path
package spb_pkg;
  localparam int DATA_W = 512;
  localparam int KEEP_W = 64;
  localparam int RAM_AW = 6;
  localparam int LEN_W = 13;
  localparam int BEAT_W = 7;
  localparam int HDR_BYTES = 38;
  localparam int HDR_WORDS = 10;
  localparam int FIFO_AW = 4;
  localparam int FIFO_CW = 5;
  localparam int FIFO_FULL_BIT = 4;
  localparam int AVS_AW = 14;
  localparam logic [2:0] RD_LAT_CYC = 3'h4;
  // register offsets, byte addresses
  localparam logic [13:0] REG_CTRL = 14'h0000;
  localparam logic [13:0] REG_TX_LEN = 14'h0004;
  localparam logic [13:0] REG_RX_STAT = 14'h0008;
  localparam logic [13:0] REG_END_WORD = 14'h000C;
  localparam logic [13:0] REG_HDR_BASE = 14'h0040;
  localparam logic [13:0] REG_MASK_BASE = 14'h0080;
  // address regions, selected by address bits 13:12
  localparam logic [1:0] REGION_REG = 2'h0;
  localparam logic [1:0] REGION_TXMEM = 2'h1;
  localparam logic [1:0] REGION_RXMEM = 2'h2;
  // field positions
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam int STAT_ACK_BIT = 0;
  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_CNT_LSB = 4;
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SEND} spb_tx_state_e;
endpackage

// File: rtl/spb_ram.sv
// dual port packet memory with byte write enables and registered read data
`timescale 1ns/1ns
module spb_ram #(
  parameter int DW = 512,
  parameter int AW = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // memory ports
  spb_ram_if.mem bus
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge clk) begin
    if (ce && bus.wr_en) begin
      for (int b = 0; b < DW/8; b++) begin
        if (bus.wr_be[b]) begin
          mem_q[bus.wr_addr][b*8 +: 8] <= bus.wr_data[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.rd_data <= '0;
    end else if (ce) begin
      bus.rd_data <= mem_q[bus.rd_addr];
    end
  end
endmodule

// File: rtl/spb_ram_if.sv
// ports of one packet memory, write side and registered read side
`timescale 1ns/1ns
interface spb_ram_if #(parameter int DW = 512, parameter int AW = 6);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW/8-1:0] wr_be;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport mem (input wr_en, input wr_addr, input wr_be, input wr_data, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_be, output wr_data, output rd_addr, input rd_data);
endinterface

// File: testbench/spb_mac_model.sv
// partner mac model: random-stall transmit sink and receive packet source
`timescale 1ns/1ns
module spb_mac_model (
  // clock
  input wire logic clk,
  // transmit stream sink
  input wire logic [511:0] tx_tdata,
  input wire logic [63:0] tx_tkeep,
  input wire logic tx_tvalid,
  input wire logic tx_tlast,
  output logic tx_tready,
  // receive stream source
  output logic [511:0] rx_tdata,
  output logic rx_tvalid,
  output logic rx_tlast
);
  int seed = 32'hb86b;
  logic rx_busy = 1'b0;
  logic stalled = 1'b0;
  logic [577:0] held;
  logic [576:0] txq[$];
  initial begin
    tx_tready = 1'b0;
    rx_tdata = '0;
    rx_tvalid = 1'b0;
    rx_tlast = 1'b0;
  end
  always @(posedge clk) begin
    if (stalled) tb.chk({tx_tvalid, tx_tlast, tx_tkeep, tx_tdata}, held);
    stalled <= tx_tvalid && !tx_tready;
    held <= {tx_tvalid, tx_tlast, tx_tkeep, tx_tdata};
    if (tx_tvalid && tx_tready) txq.push_back({tx_tlast, tx_tkeep, tx_tdata});
    tx_tready <= 1'($random(seed));
    // idle data wanders so a stale word never looks like a beat
    if (!rx_busy) rx_tdata <= {16{$random(seed)}};
  end
  // one packet: first beat w0, later beats w1
  task automatic send_pkt(input logic [511:0] w0, input logic [511:0] w1, input int n);
    rx_busy = 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      rx_tdata <= (k == 0) ? w0 : w1;
      rx_tvalid <= 1'b1;
      rx_tlast <= (k == n - 1);
    end
    @(posedge clk);
    rx_tvalid <= 1'b0;
    rx_tlast <= 1'b0;
    rx_busy = 1'b0;
  endtask
endmodule

// File: testbench/tb.sv
// self-checking bench of the slow port packet path
`timescale 1ns/1ns
module tb;
  import spb_pkg::*;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic CE = 1'b1;
  logic [13:0] AVS_ADDRESS = '0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = '0;
  logic [3:0] AVS_BYTEENABLE = '0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [511:0] TX_TDATA, RX_TDATA;
  logic [63:0] TX_TKEEP;
  logic TX_TVALID, TX_TLAST, TX_TREADY, RX_TVALID, RX_TLAST;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 32'hb86b;
  int cycles = 0;
  int lens[6] = '{100, 64, 1, 130, 256, 0};
  logic [511:0] exp_mem[4];
  logic [511:0] w0, w1;
  logic [1023:0] pk;
  spb_packet_path i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .TX_TDATA(TX_TDATA), .TX_TKEEP(TX_TKEEP), .TX_TVALID(TX_TVALID), .TX_TLAST(TX_TLAST),
    .TX_TREADY(TX_TREADY), .RX_TDATA(RX_TDATA), .RX_TVALID(RX_TVALID), .RX_TLAST(RX_TLAST));
  spb_mac_model i_mac (.clk(CLK), .tx_tdata(TX_TDATA), .tx_tkeep(TX_TKEEP), .tx_tvalid(TX_TVALID),
    .tx_tlast(TX_TLAST), .tx_tready(TX_TREADY), .rx_tdata(RX_TDATA), .rx_tvalid(RX_TVALID),
    .rx_tlast(RX_TLAST));
  initial begin
    forever #10 CLK = ~CLK;
  end
  // ceiling well above the thousand or so cycles the run needs
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      end_of_test();
    end
  end
  task chk(input logic [599:0] got, input logic [599:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [511:0] rnd512();
    logic [511:0] r;
    for (int i = 0; i < 16; i++) r[i*32 +: 32] = $random(seed);
    return r;
  endfunction
  function automatic logic [63:0] keep_of(input int len, input logic last);
    if (!last || len % 64 == 0) return '1;
    return (64'h1 << (len % 64)) - 64'h1;
  endfunction
  task automatic avs_wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] be);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= 1'b1;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rchk(input logic [13:0] a, input logic [31:0] exp, input int extra = 0);
    int waits;
    waits = 0;
    AVS_ADDRESS <= a;
    AVS_READ <= 1'b1;
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      waits++;
      @(posedge CLK);
    end
    chk(AVS_READDATA, exp);
    chk(waits, RD_LAT_CYC + extra);
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic set_mask(input logic [37:0] m, input logic en);
    avs_wr(REG_CTRL, 32'h0, 4'hF);
    avs_wr(REG_MASK_BASE, m[31:0], 4'hF);
    avs_wr(REG_MASK_BASE + 14'h4, 32'(m[37:32]), 4'hF);
    avs_wr(REG_CTRL, 32'(en) << 1, 4'hF);
  endtask
  task automatic tx_run(input int len);
    int nb;
    logic [576:0] b;
    nb = (len + 63) / 64;
    for (int w = 0; w < nb; w++) begin
      for (int s = 0; s < 16; s++) begin
        exp_mem[w][s*32 +: 32] = $random(seed);
        avs_wr(14'h1000 | 14'(w * 64 + s * 4), exp_mem[w][s*32 +: 32], 4'hF);
      end
    end
    // a single lane lands on byte 6 of word 0 only
    avs_wr(14'h1004, 32'h00A50000, 4'h4);
    exp_mem[0][55:48] = 8'hA5;
    rchk(REG_CTRL, 32'h0);
    avs_wr(REG_TX_LEN, 32'(len), 4'hF);
    avs_wr(REG_CTRL, 32'h1, 4'hF);
    rchk(REG_CTRL, 32'h1);
    while (TX_TVALID !== 1'b0 || i_mac.txq.size() < nb) @(posedge CLK);
    repeat (8) @(posedge CLK);
    rchk(REG_CTRL, 32'h0);
    chk(i_mac.txq.size(), nb);
    for (int n = 0; n < nb && i_mac.txq.size() > 0; n++) begin
      b = i_mac.txq.pop_front();
      chk(b, {1'(n == nb - 1), keep_of(len, n == nb - 1), exp_mem[n]});
    end
    i_mac.txq.delete();
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    rchk(REG_CTRL, 32'h0);
    rchk(REG_RX_STAT, 32'h1);
    // clock enable low for three cycles freezes the read counter, so three more waits
    fork
      rchk(REG_RX_STAT, 32'h1, 3);
      begin
        CE <= 1'b0;
        repeat (3) @(posedge CLK);
        CE <= 1'b1;
      end
    join
    foreach (lens[i]) tx_run(lens[i]);
    w0 = rnd512();
    w1 = rnd512();
    pk = {w1, w0};
    for (int i = 0; i < 10; i++) avs_wr(REG_HDR_BASE + 14'(i * 4), w0[i*32 +: 32], 4'hF);
    set_mask('1, 1'b1);
    i_mac.send_pkt(w0, w1, 2);
    rchk(REG_RX_STAT, 32'h10);
    rchk(REG_END_WORD, 32'h1);
    for (int i = 0; i < 32; i++) rchk(14'h2000 | 14'(i * 4), pk[i*32 +: 32]);
    avs_wr(REG_RX_STAT, 32'h1, 4'hF);
    rchk(REG_RX_STAT, 32'h1);
    // header byte 20 wrong
    i_mac.send_pkt(w0 ^ (512'hFF << 160), w1, 1);
    rchk(REG_RX_STAT, 32'h1);
    set_mask(~(38'h1 << 20), 1'b1);
    i_mac.send_pkt(w0 ^ (512'hFF << 160), w1, 1);
    rchk(REG_END_WORD, 32'h2);
    avs_wr(REG_RX_STAT, 32'h1, 4'hF);
    set_mask('1, 1'b0);
    i_mac.send_pkt(w0, w1, 1);
    rchk(REG_RX_STAT, 32'h1);
    set_mask('0, 1'b1);
    repeat (17) i_mac.send_pkt(rnd512(), w1, 1);
    rchk(REG_RX_STAT, 32'h100);
    for (int i = 0; i < 16; i++) begin
      rchk(REG_END_WORD, 32'(3 + i));
      avs_wr(REG_RX_STAT, 32'h1, 4'hF);
    end
    rchk(REG_RX_STAT, 32'h1);
    i_mac.send_pkt(w0, w1, 2);
    rchk(REG_END_WORD, 32'h14);
    end_of_test();
  end
endmodule
